// ### rtl/sbm_pkg.sv
package sbm_pkg;
  // ==========================================
  // bus widths
  localparam int ADDR_W = 32;
  localparam int CMD_W = 5;
  localparam int CNT_W = 4;
  // ==========================================
  // command lines: top bit marks a data cycle
  localparam int CMD_DATA_BIT = 4;
  localparam logic [3:0] CMD_READ = 4'h0;
  localparam logic [3:0] CMD_WRITE = 4'h8;
  localparam logic [3:0] CMD_IDLE = 4'hF;
  // data identifier bits
  localparam int DID_LAST_BIT = 0;
  localparam int DID_ERR_BIT = 1;
  localparam logic [3:0] DID_MORE = 4'h0;
  localparam logic [3:0] DID_LAST = 4'h1;
  // ==========================================
  // reset values and one-word count step
  localparam logic [31:0] RST_SAD = 32'h0000_0000;
  localparam logic [4:0] RST_CMD = 5'h0F;
  localparam logic [3:0] RST_CNT = 4'h0;
  localparam logic [3:0] ONE_WORD = 4'h1;
  // ==========================================
  // registered bus inputs
  typedef struct packed {
    logic [31:0] sad;
    logic [4:0] cmd;
    logic agent_valid_n;
    logic agent_req_n;
    logic accept_n;
  } sbm_bus_in_t;
  localparam sbm_bus_in_t BUS_IN_IDLE = '{sad: 32'h0000_0000, cmd: 5'h00,
    agent_valid_n: 1'b1, agent_req_n: 1'b1, accept_n: 1'b1};
  // ==========================================
  // interface states
  typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_WDATA, ST_SLAVE} sbm_state_t;
endpackage : sbm_pkg

// ### rtl/sbm_in_reg.sv
`timescale 1ns/10ps
module sbm_in_reg
  import sbm_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // pins in, registered out
  input wire sbm_bus_in_t d_i,
  output sbm_bus_in_t q_o
);
  sbm_bus_in_t q;
  sbm_bus_in_t next_q;

  // ==========================================
  // input capture
  always_comb begin
    next_q = d_i;
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q <= BUS_IN_IDLE;
    end else begin
      q <= next_q;
    end
  end

  assign q_o = q;
endmodule : sbm_in_reg

// ### rtl/sbm_fifo.sv
`timescale 1ns/10ps
module sbm_fifo
  import sbm_pkg::*;
#(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // fill side
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // drain side
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);

  // ==========================================
  // elaboration check
  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
    $error("sbm_fifo: depth must be a power of two >= 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, next_wr_ptr;
  logic [AW-1:0] rd_ptr, next_rd_ptr;
  logic [AW:0] count, next_count;
  logic ready, next_ready;
  logic valid, next_valid;
  logic push, pop;

  // ==========================================
  // pointers and flags
  always_comb begin
    push = in_valid_i && ready;
    pop = valid && out_ready_i;
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_count = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
    next_ready = next_count != (AW+1)'(DEPTH);
    next_valid = next_count != '0;
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      ready <= 1'b1;
      valid <= 1'b0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      ready <= next_ready;
      valid <= next_valid;
    end
  end

  // ==========================================
  // storage
  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  assign in_ready_o = ready;
  assign out_valid_o = valid;
  assign out_data_o = mem[rd_ptr];
endmodule : sbm_fifo

// ### rtl/sbm_bus_if.sv
`timescale 1ns/10ps
module sbm_bus_if
  import sbm_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // shared address/data bus
  input wire logic [ADDR_W-1:0] shared_addr_data_bus_i,
  output logic [ADDR_W-1:0] shared_addr_data_bus_o,
  output logic shared_addr_data_bus_oe_o,
  // command lines
  input wire logic [CMD_W-1:0] bus_command_lines_i,
  output logic [CMD_W-1:0] bus_command_lines_o,
  output logic bus_command_lines_oe_o,
  // handshake pins
  input wire logic agent_drive_valid_n_i,
  input wire logic agent_bus_request_n_i,
  input wire logic agent_accept_ready_n_i,
  output logic processor_drive_valid_n_o,
  output logic processor_owns_bus_n_o,
  // processor request port
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic [ADDR_W-1:0] req_addr_i,
  input wire logic [CNT_W-1:0] req_words_i,
  output logic req_ready_o,
  // write data stream
  input wire logic wdat_valid_i,
  input wire logic [ADDR_W-1:0] wdat_i,
  output logic wdat_ready_o,
  // read response out
  output logic rsp_valid_o,
  output logic [ADDR_W-1:0] rsp_data_o,
  output logic rsp_last_o,
  output logic bus_error_o,
  // external write out
  output logic ext_wr_valid_o,
  output logic [ADDR_W-1:0] ext_wr_addr_o,
  output logic [ADDR_W-1:0] ext_wr_data_o
);
  // ==========================================
  // elaboration check
  if (FIFO_DEPTH < 2) begin : g_bad
    $error("sbm_bus_if: fifo depth too small");
  end

  sbm_bus_in_t pins, inq;
  sbm_state_t state, next_state;
  logic rd_pend, next_rd_pend;
  logic have_req, next_have_req;
  logic pend_write, next_pend_write;
  logic [ADDR_W-1:0] pend_addr, next_pend_addr;
  logic [CNT_W-1:0] pend_words, next_pend_words;
  logic [CNT_W-1:0] wcnt, next_wcnt;
  logic xw_exp, next_xw_exp;
  logic [ADDR_W-1:0] sad, next_sad;
  logic sad_oe, next_sad_oe;
  logic [CMD_W-1:0] cmd, next_cmd;
  logic processor_drive_valid_n, next_processor_drive_valid_n;
  logic owns_n, next_owns_n;
  logic req_ready, next_req_ready;
  logic rsp_valid, next_rsp_valid;
  logic [ADDR_W-1:0] rsp_data, next_rsp_data;
  logic rsp_last, next_rsp_last;
  logic bus_err, next_bus_err;
  logic xw_valid, next_xw_valid;
  logic [ADDR_W-1:0] xw_addr, next_xw_addr;
  logic [ADDR_W-1:0] xw_data, next_xw_data;
  logic fifo_valid, pop, done, agent_bus_request, agent_drive_valid, issue;
  logic [ADDR_W-1:0] fifo_data;

  // ==========================================
  // input registers
  assign pins = '{sad: shared_addr_data_bus_i, cmd: bus_command_lines_i,
    agent_valid_n: agent_drive_valid_n_i, agent_req_n: agent_bus_request_n_i,
    accept_n: agent_accept_ready_n_i};

  sbm_in_reg u_in_reg (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .d_i(pins),
    .q_o(inq)
  );

  // ==========================================
  // write data buffer
  sbm_fifo #(.WIDTH(ADDR_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .in_valid_i(wdat_valid_i),
    .in_data_i(wdat_i),
    .in_ready_o(wdat_ready_o),
    .out_valid_o(fifo_valid),
    .out_data_o(fifo_data),
    .out_ready_i(pop)
  );

  // ==========================================
  // sequencer next state
  always_comb begin
    next_state = state;
    next_rd_pend = rd_pend;
    next_have_req = have_req;
    next_pend_write = pend_write;
    next_pend_addr = pend_addr;
    next_pend_words = pend_words;
    next_wcnt = wcnt;
    next_xw_exp = xw_exp;
    next_xw_addr = xw_addr;
    next_xw_data = xw_data;
    next_sad = sad;
    next_sad_oe = sad_oe;
    next_cmd = cmd;
    next_owns_n = owns_n;
    next_processor_drive_valid_n = 1'b1;
    next_rsp_valid = 1'b0;
    next_rsp_data = rsp_data;
    next_rsp_last = rsp_last;
    next_bus_err = 1'b0;
    next_xw_valid = 1'b0;
    pop = 1'b0;
    done = 1'b0;
    agent_bus_request = !inq.agent_req_n;
    agent_drive_valid = !inq.agent_valid_n;
    issue = (state == ST_ADDR) && !inq.accept_n;
    unique case (state)
      ST_IDLE: begin
        if (req_valid_i && req_ready) begin
          next_have_req = 1'b1;
          next_pend_write = req_write_i;
          next_pend_addr = req_addr_i;
          next_pend_words = req_words_i;
        end
        if (rd_pend || agent_bus_request) begin
          next_state = ST_SLAVE;
          next_owns_n = 1'b1;
          next_sad_oe = 1'b0;
        end else if (next_have_req) begin
          next_state = ST_ADDR;
          next_sad = next_pend_addr;
          next_cmd = {1'b0, next_pend_write ? CMD_WRITE : CMD_READ};
          next_processor_drive_valid_n = 1'b0;
        end
      end
      ST_ADDR: begin
        if (issue) begin
          next_have_req = 1'b0;
          if (pend_write) begin
            next_state = ST_WDATA;
            next_wcnt = pend_words;
          end else begin
            next_rd_pend = 1'b1;
            next_state = ST_SLAVE;
            next_owns_n = 1'b1;
            next_sad_oe = 1'b0;
          end
        end else if (agent_bus_request) begin
          next_state = ST_SLAVE;
          next_owns_n = 1'b1;
          next_sad_oe = 1'b0;
        end else begin
          next_processor_drive_valid_n = 1'b0;
        end
      end
      ST_WDATA: begin
        if (fifo_valid) begin
          pop = 1'b1;
          next_sad = fifo_data;
          next_processor_drive_valid_n = 1'b0;
          next_wcnt = wcnt - ONE_WORD;
          if (wcnt <= ONE_WORD) begin
            next_cmd = {1'b1, DID_LAST};
            next_state = ST_IDLE;
          end else begin
            next_cmd = {1'b1, DID_MORE};
          end
        end
      end
      ST_SLAVE: begin
        if (agent_drive_valid) begin
          if (!inq.cmd[CMD_DATA_BIT]) begin
            if (inq.cmd[3:0] == CMD_WRITE) begin
              next_xw_exp = 1'b1;
              next_xw_addr = inq.sad;
            end
          end else if (xw_exp) begin
            next_xw_exp = 1'b0;
            next_xw_valid = 1'b1;
            next_xw_data = inq.sad;
            done = 1'b1;
          end else if (rd_pend) begin
            next_rsp_valid = 1'b1;
            next_rsp_data = inq.sad;
            next_rsp_last = inq.cmd[DID_LAST_BIT];
            next_bus_err = inq.cmd[DID_ERR_BIT];
            if (inq.cmd[DID_LAST_BIT]) begin
              next_rd_pend = 1'b0;
              done = 1'b1;
            end
          end
        end
        if (done && !agent_bus_request) begin
          next_state = ST_IDLE;
          next_owns_n = 1'b0;
          next_sad_oe = 1'b1;
          next_cmd = {1'b0, CMD_IDLE};
        end
      end
    endcase
    next_req_ready = (next_state == ST_IDLE) && !next_rd_pend && !next_have_req;
  end

  // ==========================================
  // sequencer registers
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= ST_IDLE;
      rd_pend <= 1'b0;
      have_req <= 1'b0;
      pend_write <= 1'b0;
      pend_addr <= RST_SAD;
      pend_words <= RST_CNT;
      wcnt <= RST_CNT;
      xw_exp <= 1'b0;
      xw_addr <= RST_SAD;
      xw_data <= RST_SAD;
      sad <= RST_SAD;
      sad_oe <= 1'b1;
      cmd <= RST_CMD;
      processor_drive_valid_n <= 1'b1;
      owns_n <= 1'b0;
      req_ready <= 1'b1;
      rsp_valid <= 1'b0;
      rsp_data <= RST_SAD;
      rsp_last <= 1'b0;
      bus_err <= 1'b0;
      xw_valid <= 1'b0;
    end else begin
      state <= next_state;
      rd_pend <= next_rd_pend;
      have_req <= next_have_req;
      pend_write <= next_pend_write;
      pend_addr <= next_pend_addr;
      pend_words <= next_pend_words;
      wcnt <= next_wcnt;
      xw_exp <= next_xw_exp;
      xw_addr <= next_xw_addr;
      xw_data <= next_xw_data;
      sad <= next_sad;
      sad_oe <= next_sad_oe;
      cmd <= next_cmd;
      processor_drive_valid_n <= next_processor_drive_valid_n;
      owns_n <= next_owns_n;
      req_ready <= next_req_ready;
      rsp_valid <= next_rsp_valid;
      rsp_data <= next_rsp_data;
      rsp_last <= next_rsp_last;
      bus_err <= next_bus_err;
      xw_valid <= next_xw_valid;
    end
  end

  // ==========================================
  // outputs
  // straight from flops
  assign shared_addr_data_bus_o = sad;
  assign shared_addr_data_bus_oe_o = sad_oe;
  assign bus_command_lines_o = cmd;
  assign bus_command_lines_oe_o = sad_oe;
  assign processor_drive_valid_n_o = processor_drive_valid_n;
  assign processor_owns_bus_n_o = owns_n;
  assign req_ready_o = req_ready;
  assign rsp_valid_o = rsp_valid;
  assign rsp_data_o = rsp_data;
  assign rsp_last_o = rsp_last;
  assign bus_error_o = bus_err;
  assign ext_wr_valid_o = xw_valid;
  assign ext_wr_addr_o = xw_addr;
  assign ext_wr_data_o = xw_data;

  // ==========================================
  // assertions
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_rd_issue;
    state == ST_ADDR && !inq.accept_n && !pend_write;
  endsequence

  sequence s_released;
    processor_owns_bus_n_o && !shared_addr_data_bus_oe_o;
  endsequence

  sequence s_err_data;
    state == ST_SLAVE && agent_drive_valid && inq.cmd[CMD_DATA_BIT] && !xw_exp && rd_pend;
  endsequence

  a_auto_release: assert property (s_rd_issue |=> s_released ##0 rd_pend)
    else $error("no release after read issue");
  a_arb_grant: assert property (
    state == ST_IDLE && !inq.agent_req_n |=> s_released)
    else $error("no release on bus request");
  a_keep_master: assert property ($rose(processor_owns_bus_n_o) |->
    $past(!inq.agent_req_n || rd_pend || (state == ST_ADDR && !inq.accept_n)))
    else $error("bus released without cause");
  a_valid_owned: assert property (!processor_drive_valid_n_o |->
    !processor_owns_bus_n_o && shared_addr_data_bus_oe_o)
    else $error("valid while not owning bus");
  a_addr_repeat: assert property (
    state == ST_ADDR && inq.accept_n && inq.agent_req_n
    |=> state == ST_ADDR && !processor_drive_valid_n_o && $stable(sad))
    else $error("address cycle not repeated");
  a_one_pending: assert property (rd_pend || have_req |-> !req_ready_o)
    else $error("request taken while busy");
  a_bus_error: assert property (s_err_data ##0 inq.cmd[DID_ERR_BIT]
    |=> bus_error_o && rsp_valid_o)
    else $error("error data without bus error");
  a_read_done: assert property (s_err_data ##0 inq.cmd[DID_LAST_BIT]
    |=> !rd_pend)
    else $error("read still pending after last data");
  a_cmd_mark: assert property (!processor_drive_valid_n_o
    |-> bus_command_lines_o[CMD_DATA_BIT] == (state != ST_ADDR))
    else $error("command top bit wrong");
  a_return_master: assert property (
    state == ST_SLAVE && done && inq.agent_req_n
    |=> !processor_owns_bus_n_o ##1 (!processor_owns_bus_n_o || rd_pend
    || $past(!inq.agent_req_n)))
    else $error("bus not returned after completion");
endmodule : sbm_bus_if

// ### tb/sbm_agent_model.sv
`timescale 1ns/10ps
module sbm_agent_model
  import sbm_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // processor pins seen
  input wire logic [ADDR_W-1:0] p_sad_i,
  input wire logic [CMD_W-1:0] p_cmd_i,
  input wire logic p_valid_n_i,
  input wire logic p_owns_n_i,
  // agent pins driven
  output logic [ADDR_W-1:0] sad_o,
  output logic [CMD_W-1:0] cmd_o,
  output logic valid_n_o,
  output logic req_n_o,
  output logic accept_n_o,
  // scenario controls
  input wire logic acc_en_i,
  input wire logic [3:0] rsp_words_i,
  input wire logic rsp_err_i,
  input wire logic ext_go_i,
  input wire logic ext_req_i,
  input wire logic [ADDR_W-1:0] ext_addr_i,
  input wire logic [ADDR_W-1:0] ext_data_i,
  // observed processor traffic
  output logic [ADDR_W-1:0] rd_addr_o,
  output logic [7:0] wr_cnt_o,
  output logic [ADDR_W-1:0] wr_data_o,
  output logic [CMD_W-1:0] wr_cmd_o
);
  localparam logic [3:0] RSP_WAIT = 4'h2;
  logic acc_q, pend, ext, ext_ph;
  logic [3:0] widx, wait_c;
  // ==========
  // agent side of the bus
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      {sad_o, cmd_o, rd_addr_o, wr_data_o, wr_cmd_o} <= '0;
      {valid_n_o, req_n_o, accept_n_o} <= 3'h7;
      {acc_q, pend, ext, ext_ph, widx, wait_c} <= '0;
      wr_cnt_o <= 8'h0;
    end else begin
      accept_n_o <= !acc_en_i;
      acc_q <= !accept_n_o;
      // released lines keep moving
      valid_n_o <= 1'h1;
      sad_o <= ~sad_o;
      cmd_o <= ~cmd_o;
      if (!p_valid_n_i && p_cmd_i == {1'h0, CMD_READ} && acc_q) begin
        pend <= 1'h1;
        rd_addr_o <= p_sad_i;
      end
      if (!p_valid_n_i && p_cmd_i[CMD_DATA_BIT]) begin
        wr_cnt_o <= wr_cnt_o + 8'h1;
        wr_data_o <= p_sad_i;
        wr_cmd_o <= p_cmd_i;
      end
      if (ext_go_i) begin
        ext <= 1'h1;
        req_n_o <= !ext_req_i;
      end
      if (!p_owns_n_i || ext) begin
        wait_c <= 4'h0;
      end
      if (ext && p_owns_n_i) begin
        valid_n_o <= 1'h0;
        req_n_o <= 1'h1;
        ext_ph <= !ext_ph;
        ext <= !ext_ph;
        sad_o <= ext_ph ? ext_data_i : ext_addr_i;
        cmd_o <= ext_ph ? {1'h1, DID_LAST} : {1'h0, CMD_WRITE};
      end else if (pend && p_owns_n_i && wait_c != RSP_WAIT) begin
        wait_c <= wait_c + 4'h1;
      end else if (pend && p_owns_n_i) begin
        valid_n_o <= 1'h0;
        sad_o <= rd_addr_o + 32'(widx);
        cmd_o <= {1'h1, 2'h0, rsp_err_i, widx == rsp_words_i - 4'h1};
        widx <= widx + 4'h1;
        if (widx == rsp_words_i - 4'h1) begin
          pend <= 1'h0;
          widx <= 4'h0;
        end
      end
    end
  end
endmodule : sbm_agent_model

// ### tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import sbm_pkg::*;
  // ==========
  // clock, reset and pins
  logic clk = 1'h0;
  logic nrst = 1'h0;
  logic [31:0] sad_o, ag_sad, sad_in, rd_addr, wr_data, rsp_data, xw_addr, xw_data;
  logic [4:0] cmd_o, ag_cmd, cmd_in, wr_cmd;
  logic oe, cmd_oe, processor_drive_valid_n, owns_n, ag_valid_n, ag_req_n, ag_acc_n;
  logic req_ready, wdat_ready, rsp_valid, rsp_last, bus_error, xw_valid;
  logic [7:0] wr_cnt;
  logic req_valid = 1'h0, req_write = 1'h0, wdat_valid = 1'h0;
  logic [31:0] req_addr = 32'h0, wdat = 32'h0, x_addr = 32'h0, x_data = 32'h0;
  logic [3:0] req_words = 4'h1, r_words = 4'h1;
  logic acc_en = 1'h1, r_err = 1'h0, x_go = 1'h0, x_req = 1'h0;
  int n_fail = 0;
  int samples_checked = 0;
  assign sad_in = oe ? sad_o : ag_sad;
  assign cmd_in = cmd_oe ? cmd_o : ag_cmd;
  initial begin
    forever #20 clk = ~clk;
  end
  // ==========
  // design and far side
  sbm_bus_if #(.FIFO_DEPTH(8)) dut (
    .sys_clk_i(clk), .nrst_i(nrst), .shared_addr_data_bus_i(sad_in),
    .shared_addr_data_bus_o(sad_o), .shared_addr_data_bus_oe_o(oe),
    .bus_command_lines_i(cmd_in), .bus_command_lines_o(cmd_o),
    .bus_command_lines_oe_o(cmd_oe), .agent_drive_valid_n_i(ag_valid_n),
    .agent_bus_request_n_i(ag_req_n), .agent_accept_ready_n_i(ag_acc_n),
    .processor_drive_valid_n_o(processor_drive_valid_n), .processor_owns_bus_n_o(owns_n),
    .req_valid_i(req_valid), .req_write_i(req_write), .req_addr_i(req_addr),
    .req_words_i(req_words), .req_ready_o(req_ready), .wdat_valid_i(wdat_valid),
    .wdat_i(wdat), .wdat_ready_o(wdat_ready), .rsp_valid_o(rsp_valid),
    .rsp_data_o(rsp_data), .rsp_last_o(rsp_last), .bus_error_o(bus_error),
    .ext_wr_valid_o(xw_valid), .ext_wr_addr_o(xw_addr), .ext_wr_data_o(xw_data));
  sbm_agent_model agent (
    .sys_clk_i(clk), .nrst_i(nrst), .p_sad_i(sad_in), .p_cmd_i(cmd_in),
    .p_valid_n_i(processor_drive_valid_n), .p_owns_n_i(owns_n), .sad_o(ag_sad), .cmd_o(ag_cmd),
    .valid_n_o(ag_valid_n), .req_n_o(ag_req_n), .accept_n_o(ag_acc_n),
    .acc_en_i(acc_en), .rsp_words_i(r_words), .rsp_err_i(r_err), .ext_go_i(x_go),
    .ext_req_i(x_req), .ext_addr_i(x_addr), .ext_data_i(x_data), .rd_addr_o(rd_addr),
    .wr_cnt_o(wr_cnt), .wr_data_o(wr_data), .wr_cmd_o(wr_cmd));
  // ==========
  // checking and closing
  task chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %0t %s seen %h want %h", $time, what, seen, exp);
    end
  endtask : chk
  task end_sim;
    $display("compares %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim
  // ==========
  // scenarios
  task t_read(input logic [31:0] a, input logic [3:0] n, input logic e, input logic sp);
    int i;
    int k;
    @(posedge clk);
    acc_en <= 1'h0;
    r_words <= n;
    r_err <= e;
    x_req <= 1'h0;
    x_go <= sp;
    x_data <= ~a;
    @(posedge clk);
    x_go <= 1'h0;
    req_valid <= 1'h1;
    req_write <= 1'h0;
    req_addr <= a;
    @(posedge clk);
    req_valid <= 1'h0;
    for (k = 0; k < 8 && processor_drive_valid_n !== 1'h0; k++) @(negedge clk);
    repeat (3) begin
      chk({processor_drive_valid_n, owns_n, cmd_o, req_ready}, {3'h0, CMD_READ, 1'h0}, "rd addr");
      chk(sad_o, a, "rd addr held");
      @(negedge clk);
    end
    @(posedge clk);
    acc_en <= 1'h1;
    for (k = 0; k < 8 && processor_drive_valid_n === 1'h0; k++) @(negedge clk);
    chk({owns_n, oe, rd_addr}, {2'h2, a}, "auto release");
    if (sp) begin
      for (k = 0; k < 20 && xw_valid !== 1'h1; k++) @(negedge clk);
      chk({xw_valid, rsp_valid, xw_data}, {2'h2, ~a}, "split write");
    end
    for (i = 0; i < n; i++) begin
      @(negedge clk);
      for (k = 0; k < 40 && rsp_valid !== 1'h1; k++) @(negedge clk);
      chk({rsp_valid, rsp_last, bus_error}, {1'h1, (i == n - 1), e}, "rsp");
      chk(rsp_data, a + i, "rsp data");
    end
    chk({owns_n, oe}, 2'h1, "bus regained");
    for (k = 0; k < 3 && req_ready !== 1'h1; k++) @(negedge clk);
    chk(req_ready, 1'h1, "read complete");
    $display("test read done");
  endtask : t_read
  task t_write(input logic [31:0] a);
    int i;
    int k;
    logic [7:0] c0;
    for (i = 0; i < 8; i++) begin
      @(posedge clk);
      wdat_valid <= 1'h1;
      wdat <= a + i + 1;
    end
    @(posedge clk);
    wdat_valid <= 1'h0;
    acc_en <= 1'h0;
    @(negedge clk);
    chk(wdat_ready, 1'h0, "fifo full");
    c0 = wr_cnt;
    @(posedge clk);
    req_valid <= 1'h1;
    req_write <= 1'h1;
    req_addr <= a;
    req_words <= 4'h8;
    @(posedge clk);
    req_valid <= 1'h0;
    repeat (4) @(negedge clk);
    chk({processor_drive_valid_n, owns_n, cmd_o, sad_o}, {3'h0, CMD_WRITE, a}, "wr addr");
    @(posedge clk);
    acc_en <= 1'h1;
    for (k = 0; k < 40 && wr_cnt != c0 + 8'h8; k++) begin
      @(negedge clk);
      chk(owns_n, 1'h0, "write keeps bus");
    end
    chk(8'(wr_cnt - c0), 8'h8, "write words");
    chk({wr_cmd, wr_data}, {1'h1, DID_LAST, a + 32'h8}, "last word");
    for (k = 0; k < 4 && req_ready !== 1'h1; k++) @(negedge clk);
    chk({req_ready, wdat_ready}, 2'h3, "write complete");
    $display("test write done");
  endtask : t_write
  task t_arb(input logic [31:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    acc_en <= 1'h0;
    r_words <= 4'h1;
    r_err <= 1'h0;
    @(posedge clk);
    req_valid <= 1'h1;
    req_write <= 1'h0;
    req_addr <= a + 32'h100;
    @(posedge clk);
    req_valid <= 1'h0;
    x_req <= 1'h1;
    x_go <= 1'h1;
    x_addr <= a;
    x_data <= d;
    @(posedge clk);
    x_go <= 1'h0;
    for (k = 0; k < 10 && owns_n !== 1'h1; k++) @(negedge clk);
    chk({owns_n, oe}, 2'h2, "released on request");
    for (k = 0; k < 10 && xw_valid !== 1'h1; k++) @(negedge clk);
    chk({xw_valid, owns_n, oe}, 3'h5, "bus back");
    chk({xw_addr, xw_data}, {a, d}, "ext write");
    for (k = 0; k < 10 && processor_drive_valid_n !== 1'h0; k++) @(negedge clk);
    chk({processor_drive_valid_n, owns_n, cmd_o, sad_o}, {3'h0, CMD_READ, a + 32'h100}, "request kept");
    @(posedge clk);
    acc_en <= 1'h1;
    for (k = 0; k < 20 && rsp_valid !== 1'h1; k++) @(negedge clk);
    chk({rsp_valid, rsp_last, bus_error, rsp_data}, {3'h6, a + 32'h100}, "held read");
    for (k = 0; k < 4 && req_ready !== 1'h1; k++) @(negedge clk);
    chk({owns_n, oe, req_ready}, 3'h3, "held read done");
    $display("test arbitration done");
  endtask : t_arb
  task t_reset;
    repeat (8) @(posedge clk);
    nrst <= 1'h1;
    @(negedge clk);
    chk({owns_n, oe, cmd_oe, processor_drive_valid_n, req_ready, cmd_o}, {5'h0F, RST_CMD}, "reset");
    $display("test reset done");
  endtask : t_reset
  // ==========
  // main sequence and watchdog
  initial begin
    t_reset;
    t_read(32'h0000_1000, 4'h4, 1'h0, 1'h0);
    t_read(32'h0000_2000, 4'h1, 1'h1, 1'h0);
    t_write(32'h0000_3000);
    t_arb(32'h0000_0040, 32'h0000_00A5);
    t_read(32'h0000_4000, 4'h2, 1'h0, 1'h1);
    end_sim;
  end
  initial begin
    repeat (3000) @(posedge clk);
    n_fail++;
    end_sim;
  end
endmodule : tb_top
